// ==== inc/lmac_consts.vh ====
/*
 Constants for the logger mission and alarm configuration block:
 register addresses, bit positions, fixed bit patterns, log start addresses.
 Assumes inclusion by bare name from the design file.
*/
`ifndef LMAC_CONSTS_VH
`define LMAC_CONSTS_VH
`define LMAC_ADDR_TEMP_CTRL   10'h210
`define LMAC_ADDR_HUM_CTRL    10'h211
`define LMAC_ADDR_OSC_CTRL    10'h212
`define LMAC_ADDR_LOG_CTRL    10'h213
`define LMAC_ADDR_ALARM_STAT  10'h214
`define LMAC_HUM_FIXED        8'hfc
`define LMAC_LOG_FIXED        8'hc0
`define LMAC_STAT_FIXED       8'h70
`define LMAC_BIT_LOW          0
`define LMAC_BIT_HIGH         1
`define LMAC_BIT_TLOG         0
`define LMAC_BIT_HLOG         1
`define LMAC_BIT_TWIDE        2
`define LMAC_BIT_HWIDE        3
`define LMAC_BIT_WRAP         4
`define LMAC_BIT_ALARM_START  5
`define LMAC_BIT_RESTART      7
`define LMAC_LOG_BASE         16'h1000
`define LMAC_HUM_BASE_EQ      16'h2000
`define LMAC_HUM_BASE_8_16    16'h1a00
`define LMAC_HUM_BASE_16_8    16'h2400
`define LMAC_LOG_END          16'h2fff
`endif

// ==== hw/lmac_core.v ====
/*
 Mission/alarm configuration registers of a temperature and humidity logger,
 plus the log address sequencer for the data-log memory.
 Assumes a command decoder on the same clock delivering one-cycle strobes,
 sensor results with a one-cycle valid, and a byte-wide memory write port.
*/
`timescale 1ns/100ps
`include "lmac_consts.vh"
module lmac_core (
	input  wire        clock_i,
	input  wire        rst_i,
	input  wire        clk_en_i,
	input  wire        wr_i,
	input  wire [9:0]  addr_i,
	input  wire [7:0]  wdata_i,
	output reg  [7:0]  rdata_o,
	input  wire        start_mission_i,
	input  wire        stop_mission_i,
	input  wire        forced_conv_i,
	input  wire        clear_memory_i,
	input  wire [7:0]  temp_high_thr_i,
	input  wire [7:0]  temp_low_thr_i,
	input  wire [7:0]  hum_high_thr_i,
	input  wire [7:0]  hum_low_thr_i,
	input  wire        temp_valid_i,
	input  wire [15:0] temp_data_i,
	input  wire        hum_valid_i,
	input  wire [15:0] hum_data_i,
	output reg         mission_active_o,
	output reg         waiting_alarm_o,
	output reg         oscillator_run_o,
	output reg         seconds_rate_select_o,
	output reg         narrow_temp_conv_o,
	output reg         conv_enable_o,
	output reg         sample_count_o,
	output reg         mem_we_o,
	output reg  [15:0] mem_addr_o,
	output reg  [7:0]  mem_wdata_o,
	output reg         start_refused_o
);
	reg  [1:0]  temp_en_reg;
	reg  [1:0]  hum_en_reg;
	reg  [1:0]  osc_reg;
	reg  [5:0]  log_reg;
	reg  [3:0]  flags_reg;
	reg         bor_reg;
	reg         log_full_reg;
	reg  [15:0] temp_ptr_reg;
	reg  [15:0] hum_ptr_reg;
	reg  [7:0]  low_byte_reg;
	reg         low_pend_reg;
	wire [3:0]  flags_next;
	reg  [15:0] hum_base;
	reg  [15:0] temp_end;
	wire        wr_ok;
	wire        temp_log;
	wire        hum_log;
	wire        alarm_start_on;
	wire        t_hi;
	wire        t_lo;
	wire        h_hi;
	wire        h_lo;
	wire        t_alarm;
	wire        do_log_t;
	wire        do_log_h;

	assign temp_log = log_reg[`LMAC_BIT_TLOG];
	assign hum_log  = log_reg[`LMAC_BIT_HLOG];
	assign alarm_start_on = log_reg[`LMAC_BIT_ALARM_START] & temp_log;
	assign wr_ok    = wr_i & ~mission_active_o;
	// Only the upper byte is compared; lower bits are sub-LSB resolution
	assign t_hi = temp_data_i[15:8] >= temp_high_thr_i;
	assign t_lo = temp_data_i[15:8] <= temp_low_thr_i;
	assign h_hi = hum_data_i[15:8] >= hum_high_thr_i;
	assign h_lo = hum_data_i[15:8] <= hum_low_thr_i;
	assign t_alarm = (t_hi & temp_en_reg[`LMAC_BIT_HIGH]) |
			 (t_lo & temp_en_reg[`LMAC_BIT_LOW]);
	assign do_log_t = mission_active_o & temp_valid_i & temp_log &
			  ~log_full_reg & ~low_pend_reg &
			  (~waiting_alarm_o | t_alarm);
	assign do_log_h = mission_active_o & hum_valid_i & hum_log &
			  ~log_full_reg & ~low_pend_reg & ~do_log_t &
			  ~waiting_alarm_o;

	always @* begin
		// Humidity region start depends on both formats when temperature is also logged
		if (!temp_log)
			hum_base = `LMAC_LOG_BASE;
		else if (log_reg[`LMAC_BIT_TWIDE] == log_reg[`LMAC_BIT_HWIDE])
			hum_base = `LMAC_HUM_BASE_EQ;
		else if (log_reg[`LMAC_BIT_HWIDE])
			hum_base = `LMAC_HUM_BASE_8_16;
		else
			hum_base = `LMAC_HUM_BASE_16_8;
		temp_end = hum_log ? hum_base - 16'h0001 : `LMAC_LOG_END;
	end

	// Step and increment sums carry one spare bit that is dropped on purpose
	wire [16:0] addr_inc_sum;
	wire [16:0] temp_last_sum;
	wire [16:0] hum_last_sum;
	wire [16:0] temp_step;
	wire [16:0] hum_step;
	wire [16:0] temp_step_sum;
	wire [16:0] hum_step_sum;
	wire [3:0]  flag_hit;
	wire [3:0]  flag_en;
	wire [3:0]  flag_valid;
	wire        sel_temp;
	wire        sel_hum;
	wire        sel_osc;
	wire        sel_log;
	wire        start_ok;
	wire        start_go;
	wire        temp_at_end;
	wire        hum_at_end;
	wire        end_no_wrap;
	reg  [3:0]  phase_reg;
	reg  [3:0]  phase_next;
	genvar      gi;

	// One-hot mission phases
	localparam [3:0] PH_IDLE = 4'b0001;
	localparam [3:0] PH_WAIT = 4'b0010;
	localparam [3:0] PH_RUN  = 4'b0100;
	localparam [3:0] PH_FULL = 4'b1000;

	assign sel_temp = wr_ok & (addr_i == `LMAC_ADDR_TEMP_CTRL);
	assign sel_hum  = wr_ok & (addr_i == `LMAC_ADDR_HUM_CTRL);
	assign sel_osc  = wr_ok & (addr_i == `LMAC_ADDR_OSC_CTRL);
	assign sel_log  = wr_ok & (addr_i == `LMAC_ADDR_LOG_CTRL);
	assign start_ok = start_mission_i & ~mission_active_o;
	assign start_go = start_ok & (temp_log | hum_log);

	assign temp_step = log_reg[`LMAC_BIT_TWIDE] ? 17'h0_0002
						      : 17'h0_0001;
	assign hum_step  = log_reg[`LMAC_BIT_HWIDE] ? 17'h0_0002
						      : 17'h0_0001;
	assign addr_inc_sum  = {1'b0, mem_addr_o} + 17'h0_0001;
	assign temp_last_sum = {1'b0, temp_ptr_reg} +
			       {16'h0000, log_reg[`LMAC_BIT_TWIDE]};
	assign hum_last_sum  = {1'b0, hum_ptr_reg} +
			       {16'h0000, log_reg[`LMAC_BIT_HWIDE]};
	assign temp_step_sum = {1'b0, temp_ptr_reg} + temp_step;
	assign hum_step_sum  = {1'b0, hum_ptr_reg} + hum_step;
	// Last entry of a region: its final byte reaches the region end
	assign temp_at_end = temp_last_sum >= {1'b0, temp_end};
	assign hum_at_end  = hum_last_sum >= {1'b0, `LMAC_LOG_END};
	assign end_no_wrap = ~log_reg[`LMAC_BIT_WRAP] &
			     ((do_log_t & temp_at_end) | (do_log_h & hum_at_end));

	// Order follows the status byte: hum high, hum low, temp high, low
	assign flag_hit   = {h_hi, h_lo, t_hi, t_lo};
	assign flag_en    = {hum_en_reg, temp_en_reg};
	assign flag_valid = {{2{hum_valid_i}}, {2{temp_valid_i}}} &
			    {4{mission_active_o | forced_conv_i}};

	generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
		// Flags are sticky; only clear-memory takes them down
		assign flags_next[gi] = flags_reg[gi] |
			(flag_valid[gi] & flag_en[gi] & flag_hit[gi]);
	end
	endgenerate

	always @* begin
		phase_next = phase_reg;
		case (phase_reg)
		PH_IDLE: begin
			if (start_go) begin
				if (alarm_start_on)
					phase_next = PH_WAIT;
				else
					phase_next = PH_RUN;
			end
		end
		PH_WAIT: begin
			if (do_log_t)
				phase_next = end_no_wrap ? PH_FULL : PH_RUN;
		end
		PH_RUN: begin
			if (end_no_wrap)
				phase_next = PH_FULL;
		end
		PH_FULL: begin
			// Only a stop leaves a full log
			phase_next = PH_FULL;
		end
		default: begin
			phase_next = PH_IDLE;
		end
		endcase
		if (stop_mission_i)
			phase_next = PH_IDLE;
	end

	// Control registers; writes are refused while a mission runs
	always @(posedge clock_i) begin
		if (rst_i) begin
			temp_en_reg <= 2'b00;
			hum_en_reg  <= 2'b00;
			osc_reg     <= 2'b00;
			log_reg     <= 6'h00;
		end else if (clk_en_i) begin
			if (sel_temp)
				temp_en_reg <= wdata_i[1:0];
			if (sel_hum)
				hum_en_reg <= wdata_i[1:0];
			if (sel_log)
				log_reg <= wdata_i[5:0];
			if (sel_osc)
				osc_reg[1] <= wdata_i[1];
			// Commands that need the clock beat a same-cycle write
			if (forced_conv_i | start_go)
				osc_reg[0] <= 1'b1;
			else if (sel_osc)
				osc_reg[0] <= wdata_i[0];
		end
	end

	always @(posedge clock_i) begin
		if (rst_i) begin
			flags_reg <= 4'h0;
			bor_reg   <= 1'b1;
		end else if (clk_en_i) begin
			// A same-cycle alarm event survives the clear unless its flag was already set
			if (clear_memory_i) begin
				flags_reg <= flags_next & ~flags_reg;
				bor_reg   <= 1'b0;
			end else begin
				flags_reg <= flags_next;
			end
		end
	end

	always @(posedge clock_i) begin
		if (rst_i) begin
			phase_reg        <= PH_IDLE;
			mission_active_o <= 1'b0;
			log_full_reg     <= 1'b0;
			waiting_alarm_o  <= 1'b0;
			start_refused_o  <= 1'b0;
		end else if (clk_en_i) begin
			phase_reg        <= phase_next;
			mission_active_o <= (phase_next != PH_IDLE);
			log_full_reg     <= (phase_next == PH_FULL);
			start_refused_o  <= start_ok & ~(temp_log | hum_log);
			// The wait flag outlives a stop until the next start
			if (start_go)
				waiting_alarm_o <= alarm_start_on;
			else if (do_log_t & waiting_alarm_o)
				waiting_alarm_o <= 1'b0;
		end
	end

	always @(posedge clock_i) begin
		if (rst_i) begin
			temp_ptr_reg <= `LMAC_LOG_BASE;
			hum_ptr_reg  <= `LMAC_LOG_BASE;
			low_byte_reg <= 8'h00;
		end else if (clk_en_i) begin
			if (start_go) begin
				temp_ptr_reg <= `LMAC_LOG_BASE;
				hum_ptr_reg  <= hum_base;
			end
			if (do_log_t) begin
				if (!temp_at_end)
					temp_ptr_reg <= temp_step_sum[15:0];
				else if (log_reg[`LMAC_BIT_WRAP])
					temp_ptr_reg <= `LMAC_LOG_BASE;
			end
			if (do_log_h) begin
				if (!hum_at_end)
					hum_ptr_reg <= hum_step_sum[15:0];
				else if (log_reg[`LMAC_BIT_WRAP])
					hum_ptr_reg <= hum_base;
			end
			if (do_log_t)
				low_byte_reg <= temp_data_i[7:0];
			else if (do_log_h)
				low_byte_reg <= hum_data_i[7:0];
		end
	end

	always @(posedge clock_i) begin
		if (rst_i) begin
			low_pend_reg   <= 1'b0;
			mem_we_o       <= 1'b0;
			mem_addr_o     <= 16'h0000;
			mem_wdata_o    <= 8'h00;
			sample_count_o <= 1'b0;
		end else if (clk_en_i) begin
			mem_we_o       <= 1'b0;
			sample_count_o <= 1'b0;
			if (do_log_t) begin
				// The trigger sample is logged but not counted
				sample_count_o <= ~waiting_alarm_o;
				mem_we_o       <= 1'b1;
				mem_addr_o     <= temp_ptr_reg;
				mem_wdata_o    <= temp_data_i[15:8];
				low_pend_reg   <= log_reg[`LMAC_BIT_TWIDE] &
						  ~alarm_start_on;
			end else if (do_log_h) begin
				// With both streams logged the pair counts once
				sample_count_o <= ~temp_log;
				mem_we_o       <= 1'b1;
				mem_addr_o     <= hum_ptr_reg;
				mem_wdata_o    <= hum_data_i[15:8];
				low_pend_reg   <= log_reg[`LMAC_BIT_HWIDE];
			end else if (low_pend_reg) begin
				// Low byte follows at the next address
				mem_we_o     <= 1'b1;
				mem_addr_o   <= addr_inc_sum[15:0];
				mem_wdata_o  <= low_byte_reg;
				low_pend_reg <= 1'b0;
			end
		end
	end

	// Read data is registered: it answers the address of the last cycle
	always @(posedge clock_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (clk_en_i) begin
			case (addr_i)
			`LMAC_ADDR_TEMP_CTRL:
				rdata_o <= {6'h00, temp_en_reg};
			`LMAC_ADDR_HUM_CTRL:
				rdata_o <= `LMAC_HUM_FIXED | {6'h00, hum_en_reg};
			`LMAC_ADDR_OSC_CTRL:
				rdata_o <= {6'h00, osc_reg};
			`LMAC_ADDR_LOG_CTRL:
				rdata_o <= `LMAC_LOG_FIXED | {2'b00, log_reg};
			`LMAC_ADDR_ALARM_STAT:
				rdata_o <= `LMAC_STAT_FIXED |
					   {bor_reg, 3'b000, flags_reg};
			default:
				rdata_o <= 8'h00;
			endcase
		end
	end

	always @(posedge clock_i) begin
		if (rst_i) begin
			oscillator_run_o      <= 1'b0;
			seconds_rate_select_o <= 1'b0;
			narrow_temp_conv_o    <= 1'b0;
			conv_enable_o         <= 1'b0;
		end else if (clk_en_i) begin
			oscillator_run_o      <= osc_reg[0];
			seconds_rate_select_o <= osc_reg[1];
			narrow_temp_conv_o    <= waiting_alarm_o;
			conv_enable_o <= mission_active_o & ~log_full_reg;
		end
	end
endmodule

// ==== testbench/lmac_checker.sv ====
/*
 Port-level checker for the logger mission and alarm configuration block.
 Assumes clk_en_i is held high and bind by port name onto lmac_core.
*/
`timescale 1ns/100ps
module lmac_checker (
	input wire       clock_i,
	input wire       rst_i,
	input wire [9:0] addr_i,
	input wire [7:0] rdata_o,
	input wire       start_mission_i,
	input wire       stop_mission_i,
	input wire       forced_conv_i,
	input wire       mission_active_o,
	input wire       start_refused_o,
	input wire       oscillator_run_o,
	input wire       mem_we_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	property p_start;
		start_mission_i && !mission_active_o |=>
			mission_active_o != start_refused_o;
	endproperty
	a_start: assert property (p_start)
		else $error("start gave neither mission nor refusal");
	property p_refuse; start_refused_o |-> !mission_active_o; endproperty
	a_refuse: assert property (p_refuse)
		else $error("refused start left a mission running");
	property p_stop; stop_mission_i |=> !mission_active_o; endproperty
	a_stop: assert property (p_stop)
		else $error("mission still active after stop");
	property p_osc; forced_conv_i |-> ##2 oscillator_run_o; endproperty
	a_osc: assert property (p_osc)
		else $error("oscillator not running after forced conversion");
	property p_rd_temp; addr_i == 10'h210 |=> rdata_o[7:2] == 6'h00; endproperty
	a_rd_temp: assert property (p_rd_temp)
		else $error("temperature control upper bits not zero");
	property p_rd_hum; addr_i == 10'h211 |=> rdata_o[7:2] == 6'h3f; endproperty
	a_rd_hum: assert property (p_rd_hum)
		else $error("humidity control upper bits not one");
	property p_rd_stat; addr_i == 10'h214 |=> rdata_o[6:4] == 3'h7; endproperty
	a_rd_stat: assert property (p_rd_stat)
		else $error("alarm status fixed bits not one");
	property p_idle; (!mission_active_o)[*3] |-> !mem_we_o; endproperty
	a_idle: assert property (p_idle)
		else $error("log write outside a mission");
	cover property (start_mission_i ##1 mission_active_o);
	cover property (start_refused_o);
	cover property (mem_we_o ##1 mem_we_o);
endmodule
bind lmac_core lmac_checker i_lmac_checker (.clock_i(clock_i),
	.rst_i(rst_i), .addr_i(addr_i), .rdata_o(rdata_o),
	.start_mission_i(start_mission_i), .stop_mission_i(stop_mission_i),
	.forced_conv_i(forced_conv_i), .mission_active_o(mission_active_o),
	.start_refused_o(start_refused_o), .oscillator_run_o(oscillator_run_o),
	.mem_we_o(mem_we_o));

// ==== testbench/lmac_host_model.sv ====
/*
 Host side of the register bus: write and read tasks.
 Assumes rdata_i follows the address one cycle later.
*/
`timescale 1ns/100ps
module lmac_host_model (
	input  wire       clock_i,
	input  wire [7:0] rdata_i,
	output reg        wr_o,
	output reg  [9:0] addr_o,
	output reg  [7:0] wdata_o
);
	initial begin
		wr_o = 1'b0;
		addr_o = 10'h000;
		wdata_o = 8'h00;
	end
	task wr(input [9:0] a, input [7:0] d);
		begin
			@(posedge clock_i);
			wr_o <= 1'b1;
			addr_o <= a;
			wdata_o <= d;
			@(posedge clock_i);
			wr_o <= 1'b0;
			// Released data shows junk so a stale byte is never reused
			wdata_o <= ~d;
		end
	endtask
	task rd(input [9:0] a, output [7:0] d);
		begin
			@(posedge clock_i);
			addr_o <= a;
			@(posedge clock_i);
			@(posedge clock_i);
			d = rdata_i;
		end
	endtask
endmodule

// ==== testbench/tb_top.sv ====
/*
 Self-checking bench for the mission and alarm configuration block.
 Assumes lmac_core, its checker and the host model are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
	reg         clock_i;
	reg         rst_i;
	reg         st_r, sp_r, fc_r, cm_r, tv_r, hv_r;
	reg  [15:0] td_r;
	wire        wr_w, act_w, osc_w, sec_w, cnt_w, we_w, ref_w;
	wire        wait_w, nar_w, conv_w;
	wire [9:0]  addr_w;
	wire [7:0]  wd_w, rd_w, md_w;
	wire [15:0] ma_w;
	integer     n_fail, tests_run;
	reg  [7:0]  d;
	lmac_host_model i_lmac_host_model (.clock_i(clock_i), .rdata_i(rd_w),
		.wr_o(wr_w), .addr_o(addr_w), .wdata_o(wd_w));
	lmac_core i_lmac_core (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(1'b1),
		.wr_i(wr_w), .addr_i(addr_w), .wdata_i(wd_w), .rdata_o(rd_w),
		.start_mission_i(st_r), .stop_mission_i(sp_r), .forced_conv_i(fc_r),
		.clear_memory_i(cm_r), .temp_high_thr_i(8'h90),
		.temp_low_thr_i(8'h00), .hum_high_thr_i(8'h00),
		.hum_low_thr_i(8'hff), .temp_valid_i(tv_r), .temp_data_i(td_r),
		.hum_valid_i(hv_r), .hum_data_i(td_r), .mission_active_o(act_w),
		.waiting_alarm_o(wait_w), .oscillator_run_o(osc_w),
		.seconds_rate_select_o(sec_w), .narrow_temp_conv_o(nar_w),
		.conv_enable_o(conv_w), .sample_count_o(cnt_w), .mem_we_o(we_w),
		.mem_addr_o(ma_w), .mem_wdata_o(md_w), .start_refused_o(ref_w));
	task chk(input [25:0] e, input [25:0] g);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("unexpected at %0t: want %h got %h", $time, e, g);
			end
		end
	endtask
	task rc(input [9:0] a, input [7:0] e);
		begin
			i_lmac_host_model.rd(a, d);
			chk(e, d);
		end
	endtask
	task wc(input [9:0] a, input [7:0] w, input [7:0] e);
		begin
			i_lmac_host_model.wr(a, w);
			rc(a, e);
		end
	endtask
	// Pulse 0 start, 1 stop, 2 forced conversion, 3 clear memory
	task cmd(input [1:0] c);
		begin
			@(posedge clock_i);
			{cm_r, fc_r, sp_r, st_r} <= 4'h1 << c;
			@(posedge clock_i);
			{cm_r, fc_r, sp_r, st_r} <= 4'h0;
			#1;
		end
	endtask
	task samp(input h, input [15:0] v, input [15:0] a, input w);
		begin
			@(posedge clock_i);
			tv_r <= !h;
			hv_r <= h;
			td_r <= v;
			@(posedge clock_i);
			{tv_r, hv_r} <= 2'h0;
			#1 chk({we_w, ma_w, md_w}, {1'b1, a, v[15:8]});
			if (!h) chk(cnt_w, 1'b1);
			if (w) begin
				@(posedge clock_i);
				#1 chk({we_w, ma_w, md_w}, {1'b1, a + 16'h0001, v[7:0]});
			end
		end
	endtask
	task t_reset;
		begin
			rc(10'h210, 8'h00);
			rc(10'h211, 8'hfc);
			rc(10'h212, 8'h00);
			rc(10'h213, 8'hc0);
			rc(10'h214, 8'hf0);
			rc(10'h215, 8'h00);
			$display("test reset done");
		end
	endtask
	task t_fixed;
		begin
			wc(10'h210, 8'hff, 8'h03);
			wc(10'h211, 8'h00, 8'hfc);
			wc(10'h212, 8'hff, 8'h03);
			chk({osc_w, sec_w}, 2'h3);
			wc(10'h213, 8'h00, 8'hc0);
			wc(10'h214, 8'h00, 8'hf0);
			wc(10'h212, 8'h00, 8'h00);
			chk({osc_w, sec_w}, 2'h0);
			cmd(2'd2);
			@(posedge clock_i);
			#1 chk(osc_w, 1'b1);
			$display("test fixed bits done");
		end
	endtask
	task t_mission;
		begin
			cmd(2'd0);
			chk({ref_w, act_w}, 2'h2);
			i_lmac_host_model.wr(10'h213, 8'h0b);
			cmd(2'd0);
			chk({ref_w, act_w}, 2'h1);
			wc(10'h210, 8'h00, 8'h03);
			samp(1'b0, 16'h90ff, 16'h1000, 1'b0);
			samp(1'b1, 16'h1234, 16'h1a00, 1'b1);
			rc(10'h214, 8'hf2);
			cmd(2'd1);
			chk(act_w, 1'b0);
			cmd(2'd3);
			rc(10'h214, 8'h70);
			$display("test mission done");
		end
	endtask
	task t_alarm_start;
		begin
			i_lmac_host_model.wr(10'h213, 8'h21);
			cmd(2'd0);
			@(posedge clock_i);
			#1 chk({wait_w, nar_w, act_w}, 3'h7);
			@(posedge clock_i);
			tv_r <= 1'b1;
			td_r <= 16'h5000;
			@(posedge clock_i);
			tv_r <= 1'b0;
			#1 chk(we_w, 1'b0);
			@(posedge clock_i);
			tv_r <= 1'b1;
			td_r <= 16'h9500;
			@(posedge clock_i);
			tv_r <= 1'b0;
			#1 chk({we_w, ma_w, md_w, cnt_w}, 26'h220_012a);
			@(posedge clock_i);
			#1 chk({wait_w, conv_w}, 2'h1);
			cmd(2'd1);
			$display("test alarm start done");
		end
	endtask
	task wrap_up;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, n_fail);
			if (n_fail == 0 && tests_run > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	initial begin
		#(3000 * 100);
		n_fail = n_fail + 1;
		wrap_up;
	end
	initial begin
		{st_r, sp_r, fc_r, cm_r, tv_r, hv_r} = 6'h00;
		td_r = 16'h0000;
		n_fail = 0;
		tests_run = 0;
		rst_i = 1'b1;
		repeat (8) @(posedge clock_i);
		rst_i <= 1'b0;
		t_reset;
		t_fixed;
		t_mission;
		t_alarm_start;
		wrap_up;
	end
endmodule
